// ### sdcmd_pkg_buf.sv
/*
 Shared constants of the command interface and its two-entry command buffer.
 Assumes one clock, sys_clk_i at 40 MHz, and an active-low asynchronous reset.
*/
package sdcmd_pkg;
   localparam int          ADDR_W          = 13;
   localparam int          BANK_W          = 2;
   localparam int          NUM_BANKS       = 4;
   localparam int          PIN_W           = 21;
   localparam int          P_ADDR_LO       = 0;
   localparam int          P_BA_LO         = 13;
   localparam int          P_DQM           = 15;
   localparam int          P_WE_N          = 16;
   localparam int          P_CAS_N         = 17;
   localparam int          P_RAS_N         = 18;
   localparam int          P_CS_N          = 19;
   localparam int          P_CKE           = 20;
   localparam int          A_AUTO_PRE      = 10;
   localparam int          MR_BL_LO        = 0;
   localparam int          MR_BT           = 3;
   localparam int          MR_RL_LO        = 4;
   localparam int          MR_WB           = 9;
   localparam int          EMR_PAR_LO      = 0;
   localparam int          EMR_TCR_LO      = 3;
   localparam logic [12:0] MR_RESET        = 13'h0020;
   localparam logic [12:0] EMR_RESET       = 13'h0000;
   localparam logic [12:0] MR_USED_MASK    = 13'h027F;
   localparam logic [12:0] EMR_USED_MASK   = 13'h001F;
   localparam logic [1:0]  SEL_MAIN_MR     = 2'h0;
   localparam logic [1:0]  SEL_EXT_MR      = 2'h2;
   localparam logic [2:0]  RL_TWO          = 3'h2;
   localparam logic [1:0]  LAT_TWO         = 2'h2;
   localparam logic [1:0]  LAT_THREE       = 2'h3;
   localparam logic [1:0]  TCR_SENSOR      = 2'h0;
   localparam logic [2:0]  BL_FULL_PAGE    = 3'h7;
   localparam logic [9:0]  FULL_PAGE_BEATS = 10'h200;
   localparam logic [1:0]  DQM_LATENCY     = 2'h2;
   localparam int          CLK_PERIOD_PS   = 25000;
   localparam int          MODE_SET_WAIT_CK                = 2;
   localparam int          ACTIVATE_TO_ACCESS_DELAY_NS     = 19;
   localparam int          SAME_BANK_ACTIVATE_PERIOD_NS    = 67;
   localparam int          CROSS_BANK_ACTIVATE_DELAY_NS    = 15;
   localparam int          ACTIVATE_TO_ACCESS_DELAY_CK     = (ACTIVATE_TO_ACCESS_DELAY_NS * 1000
                                                              + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int          SAME_BANK_ACTIVATE_PERIOD_CK    = (SAME_BANK_ACTIVATE_PERIOD_NS * 1000
                                                              + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int          CROSS_BANK_ACTIVATE_DELAY_CK    = (CROSS_BANK_ACTIVATE_DELAY_NS * 1000
                                                              + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

   typedef enum logic [3:0] {
      SDCMD_ACTIVATE,
      SDCMD_READ,
      SDCMD_WRITE,
      SDCMD_BURST_STOP,
      SDCMD_DEEP_PD,
      SDCMD_PRECHARGE,
      SDCMD_AUTO_REFRESH,
      SDCMD_SELF_REFRESH,
      SDCMD_MODE_SET
   } sdcmd_kind_type;

   localparam int          ENTRY_W         = 4 + BANK_W + ADDR_W + 1;
endpackage

`timescale 1ns/10ps
module sdcmd_buf #(
   parameter int W = 20
) (
   input  wire logic         sys_clk_i,
   input  wire logic         resetn_i,
   input  wire logic         in_valid_i,
   output logic              in_ready_o,
   input  wire logic [W-1:0] in_data_i,
   output logic              out_valid_o,
   input  wire logic         out_ready_i,
   output logic [W-1:0]      out_data_o
);
   typedef struct packed {
      logic [W-1:0] slot0;
      logic [W-1:0] slot1;
      logic [1:0]   count;
      logic         valid;
   } sdcmd_buf_type;

   sdcmd_buf_type cur;
   sdcmd_buf_type next_cur;

   always_comb
   begin
      next_cur = cur;
      if (out_ready_i && cur.count != 2'h0)
      begin
         next_cur.slot0 = cur.slot1;
         next_cur.count = cur.count - 2'h1;
      end
      if (in_valid_i && cur.count != 2'h2)
      begin
         if (next_cur.count == 2'h0)
            next_cur.slot0 = in_data_i;
         else
            next_cur.slot1 = in_data_i;
         next_cur.count = next_cur.count + 2'h1;
      end
      next_cur.valid = next_cur.count != 2'h0;
   end

   always_ff @(posedge sys_clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
         cur <= '0;
      else
         cur <= next_cur;
   end

   assign in_ready_o  = cur.count != 2'h2;
   assign out_valid_o = cur.valid;
   assign out_data_o  = cur.slot0;
endmodule

// ### sdcmd_core.sv
/*
 Command interface of a stacked low-power SDRAM die: pin command decode, mode registers,
 bank state, refresh addressing, burst and DQM output/mask timing, decoded command stream.
 Assumes pins arrive unsynchronised and are sampled on the rising edge of sys_clk_i.
*/
// Function
// - Partial-array refresh limits self refresh to four, two, one, half or quarter bank.
// - Regions left out of partial-array refresh are not refreshed during self refresh and lose data.
// - Temp-comp code 00 uses the sensor; other codes disable it.
// - Deselect and no-operation behave alike, start nothing, disturb nothing.
// - Activate opens the bank on the bank pins with the row on address.
// - Read or write burst by write-enable; address bit ten requests auto precharge.
// - Burst stop with clock enable high, deep power down with it low.
// - Precharge closes the named bank, or all banks when bit ten is high.
// - Auto refresh with clock enable high, self refresh entry with it low.
// - Refresh uses internal row and bank counter; other inputs ignored.
// - Mode set writes main or extended register by bank code; others reserved.
// - Mask high blocks write data and floats read outputs two clocks later.
// - All inputs are sampled on the rising clock edge.
// - Shared pins mean a command to one die may change the other die.
// - Main register holds burst length, type, read latency, write burst mode.
// - Extended register holds partial-array and temp-comp fields.
// - Read latency is two or three clocks.
`timescale 1ns/10ps
module sdcmd_core
   import sdcmd_pkg::*;
#(
   parameter logic [2:0] PAR_ALL_CODE     = 3'h0,
   parameter logic [2:0] PAR_TWO_CODE     = 3'h1,
   parameter logic [2:0] PAR_ONE_CODE     = 3'h2,
   parameter logic [2:0] PAR_HALF_CODE    = 3'h5,
   parameter logic [2:0] PAR_QUARTER_CODE = 3'h6,
   parameter int         SR_TICK_CYCLES   = 64
) (
   input  wire logic                      sys_clk_i,
   input  wire logic                      resetn_i,
   input  wire logic                      cke_i,
   input  wire logic                      cs_n_i,
   input  wire logic                      ras_n_i,
   input  wire logic                      cas_n_i,
   input  wire logic                      we_n_i,
   input  wire logic                      dqm_i,
   input  wire logic [sdcmd_pkg::BANK_W-1:0] ba_i,
   input  wire logic [sdcmd_pkg::ADDR_W-1:0] addr_i,
   output logic                           cmd_valid_o,
   input  wire logic                      cmd_ready_i,
   output sdcmd_pkg::sdcmd_kind_type      cmd_kind_o,
   output logic [sdcmd_pkg::BANK_W-1:0]   cmd_bank_o,
   output logic [sdcmd_pkg::ADDR_W-1:0]   cmd_addr_o,
   output logic                           cmd_flag_o,
   output logic                           cmd_overflow_o,
   output logic [2:0]                     burst_length_o,
   output logic                           burst_interleave_o,
   output logic [1:0]                     read_latency_o,
   output logic                           write_single_o,
   output logic [2:0]                     partial_array_refresh_o,
   output logic [1:0]                     temp_comp_refresh_o,
   output logic                           temp_sensor_en_o,
   output logic [sdcmd_pkg::NUM_BANKS-1:0] bank_open_o,
   output logic                           self_refresh_o,
   output logic                           deep_power_down_o,
   output logic                           refresh_pulse_o,
   output logic [sdcmd_pkg::BANK_W-1:0]   refresh_bank_o,
   output logic [sdcmd_pkg::ADDR_W-1:0]   refresh_row_o,
   output logic                           dq_oe_o,
   output logic                           write_mask_o
);
   import sdcmd_pkg::*;

   typedef struct packed {
      logic [PIN_W-1:0]     pin_meta;
      logic [PIN_W-1:0]     pin;
      logic [ADDR_W-1:0]    mode;
      logic [ADDR_W-1:0]    ext_mode;
      logic                 sensor_en;
      logic [1:0]           latency;
      logic [NUM_BANKS-1:0] bank_open;
      logic                 self_ref;
      logic                 deep_pd;
      logic [ADDR_W-1:0]    ref_row;
      logic [BANK_W-1:0]    ref_bank;
      logic                 ref_pulse;
      logic [15:0]          sr_div;
      logic                 rd_burst;
      logic                 wr_burst;
      logic                 burst_ap;
      logic [BANK_W-1:0]    burst_bank;
      logic [1:0]           lat_cnt;
      logic [9:0]           beats;
      logic                 dqm_prev;
      logic                 dq_oe;
      logic                 wmask;
      logic                 overflow;
   } sdcmd_state_type;

   sdcmd_state_type cur;
   sdcmd_state_type next_cur;

   logic              push;
   logic [ENTRY_W-1:0] push_data;
   logic              buf_ready;
   logic [ENTRY_W-1:0] pop_data;

   function automatic logic [9:0] beats_of(input logic [2:0] code);
      case (code)
         3'h0:    beats_of = 10'h001;
         3'h1:    beats_of = 10'h002;
         3'h2:    beats_of = 10'h004;
         3'h3:    beats_of = 10'h008;
         default: beats_of = FULL_PAGE_BEATS;
      endcase
   endfunction

   function automatic logic [ENTRY_W-1:0] pack_cmd(input sdcmd_kind_type k, input logic [BANK_W-1:0] b,
                                                  input logic [ADDR_W-1:0] a, input logic f);
      pack_cmd = {k, b, a, f};
   endfunction

   // Decoded view of the synchronised pins
   logic                 cke;
   logic                 sel;
   logic [2:0]           rcw;
   logic                 dqm;
   logic [BANK_W-1:0]    ba;
   logic [ADDR_W-1:0]    addr;
   logic                 is_act;
   logic                 is_rd;
   logic                 is_wr;
   logic                 is_bst;
   logic                 is_pre;
   logic                 is_ref;
   logic                 is_mrs;
   logic                 live;

   always_comb
   begin
      cke    = cur.pin[P_CKE];
      sel    = !cur.pin[P_CS_N];
      rcw    = {cur.pin[P_RAS_N], cur.pin[P_CAS_N], cur.pin[P_WE_N]};
      dqm    = cur.pin[P_DQM];
      ba     = cur.pin[P_BA_LO +: BANK_W];
      addr   = cur.pin[P_ADDR_LO +: ADDR_W];
      live   = !cur.self_ref && !cur.deep_pd;
      is_act = live && sel && rcw == 3'b011 && cke;
      is_rd  = live && sel && rcw == 3'b101 && cke;
      is_wr  = live && sel && rcw == 3'b100 && cke;
      is_bst = live && sel && rcw == 3'b110;
      is_pre = live && sel && rcw == 3'b010 && cke;
      is_ref = live && sel && rcw == 3'b001;
      is_mrs = live && sel && rcw == 3'b000 && cke;
   end

   always_comb
   begin
      next_cur           = cur;
      push               = 1'b0;
      push_data          = '0;
      next_cur.pin_meta  = {cke_i, cs_n_i, ras_n_i, cas_n_i, we_n_i, dqm_i, ba_i, addr_i};
      next_cur.pin       = cur.pin_meta;
      next_cur.ref_pulse = 1'b0;
      next_cur.wmask     = 1'b0;
      next_cur.dqm_prev  = dqm;
      // Burst progress, frozen while clock enable is low
      if (cke)
      begin
         if (cur.rd_burst && cur.lat_cnt != 2'h0)
            next_cur.lat_cnt = cur.lat_cnt - 2'h1;
         else if ((cur.rd_burst || cur.wr_burst) && cur.beats != 10'h000)
         begin
            next_cur.beats = cur.beats - 10'h001;
            if (cur.wr_burst)
               next_cur.wmask = dqm;
         end
         else if (cur.rd_burst || cur.wr_burst)
         begin
            next_cur.rd_burst = 1'b0;
            next_cur.wr_burst = 1'b0;
            if (cur.burst_ap)
               next_cur.bank_open[cur.burst_bank] = 1'b0;
         end
      end
      next_cur.dq_oe = next_cur.rd_burst && next_cur.lat_cnt == 2'h0 && !cur.dqm_prev;
      // Low-power exits
      if ((cur.self_ref || cur.deep_pd) && cke)
      begin
         next_cur.self_ref = 1'b0;
         next_cur.deep_pd  = 1'b0;
      end
      // Self refresh walks only the retained region
      if (cur.self_ref)
      begin
         if (cur.sr_div == 16'(SR_TICK_CYCLES - 1))
         begin
            next_cur.sr_div    = '0;
            next_cur.ref_pulse = 1'b1;
            {next_cur.ref_bank, next_cur.ref_row} = {cur.ref_bank, cur.ref_row} + 15'h0001;
            case (cur.ext_mode[EMR_PAR_LO +: 3])
               PAR_ALL_CODE:     ;
               PAR_TWO_CODE:     next_cur.ref_bank[1] = 1'b0;
               PAR_ONE_CODE:     next_cur.ref_bank = '0;
               PAR_HALF_CODE:
               begin
                  next_cur.ref_bank = '0;
                  next_cur.ref_row[ADDR_W-1] = 1'b0;
               end
               PAR_QUARTER_CODE:
               begin
                  next_cur.ref_bank = '0;
                  next_cur.ref_row[ADDR_W-1 -: 2] = 2'h0;
               end
               default:          ;
            endcase
         end
         else
            next_cur.sr_div = cur.sr_div + 16'h0001;
      end
      // Command decode
      if (is_act)
      begin
         next_cur.bank_open[ba] = 1'b1;
         push      = 1'b1;
         push_data = pack_cmd(SDCMD_ACTIVATE, ba, addr, 1'b0);
      end
      else if (is_rd || is_wr)
      begin
         next_cur.rd_burst   = is_rd;
         next_cur.wr_burst   = is_wr;
         next_cur.burst_ap   = addr[A_AUTO_PRE];
         next_cur.burst_bank = ba;
         next_cur.lat_cnt    = is_rd ? cur.latency - 2'h1 : 2'h0;
         next_cur.beats      = (is_wr && cur.mode[MR_WB]) ? 10'h000
                               : beats_of(cur.mode[MR_BL_LO +: 3]) - 10'h001;
         next_cur.wmask      = is_wr && dqm;
         next_cur.dq_oe      = 1'b0;
         push      = 1'b1;
         push_data = pack_cmd(is_rd ? SDCMD_READ : SDCMD_WRITE, ba, addr, addr[A_AUTO_PRE]);
      end
      else if (is_bst)
      begin
         if (cke)
         begin
            if (!cur.burst_ap)
            begin
               next_cur.rd_burst = 1'b0;
               next_cur.wr_burst = 1'b0;
               next_cur.dq_oe    = 1'b0;
            end
         end
         else
            next_cur.deep_pd = 1'b1;
         push      = 1'b1;
         push_data = pack_cmd(cke ? SDCMD_BURST_STOP : SDCMD_DEEP_PD, '0, '0, 1'b0);
      end
      else if (is_pre)
      begin
         if (addr[A_AUTO_PRE])
            next_cur.bank_open = '0;
         else
            next_cur.bank_open[ba] = 1'b0;
         push      = 1'b1;
         push_data = pack_cmd(SDCMD_PRECHARGE, addr[A_AUTO_PRE] ? '0 : ba, '0, addr[A_AUTO_PRE]);
      end
      else if (is_ref)
      begin
         push      = 1'b1;
         push_data = pack_cmd(cke ? SDCMD_AUTO_REFRESH : SDCMD_SELF_REFRESH,
                              cur.ref_bank, cur.ref_row, 1'b0);
         if (cke)
         begin
            next_cur.ref_pulse = 1'b1;
            {next_cur.ref_bank, next_cur.ref_row} = {cur.ref_bank, cur.ref_row} + 15'h0001;
         end
         else
         begin
            next_cur.self_ref = 1'b1;
            next_cur.sr_div   = '0;
         end
      end
      else if (is_mrs)
      begin
         if (ba == SEL_MAIN_MR)
         begin
            next_cur.mode    = addr & MR_USED_MASK;
            next_cur.latency = (addr[MR_RL_LO +: 3] == RL_TWO) ? LAT_TWO : LAT_THREE;
         end
         else if (ba == SEL_EXT_MR)
         begin
            next_cur.ext_mode  = addr & EMR_USED_MASK;
            next_cur.sensor_en = addr[EMR_TCR_LO +: 2] == TCR_SENSOR;
         end
         push      = 1'b1;
         push_data = pack_cmd(SDCMD_MODE_SET, ba, addr, 1'b0);
      end
      if (push && !buf_ready)
         next_cur.overflow = 1'b1;
   end

   always_ff @(posedge sys_clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         cur           <= '0;
         cur.pin_meta  <= {1'b1, 1'b1, 19'h00000};
         cur.pin       <= {1'b1, 1'b1, 19'h00000};
         cur.mode      <= MR_RESET;
         cur.ext_mode  <= EMR_RESET;
         cur.sensor_en <= 1'b1;
         cur.latency   <= LAT_TWO;
      end
      else
         cur <= next_cur;
   end

   sdcmd_buf #(
      .W           (ENTRY_W)
   ) u_cmd_buf (
      .sys_clk_i   (sys_clk_i),
      .resetn_i    (resetn_i),
      .in_valid_i  (push),
      .in_ready_o  (buf_ready),
      .in_data_i   (push_data),
      .out_valid_o (cmd_valid_o),
      .out_ready_i (cmd_ready_i),
      .out_data_o  (pop_data)
   );

   assign cmd_kind_o              = sdcmd_kind_type'(pop_data[ENTRY_W-1 -: 4]);
   assign cmd_bank_o              = pop_data[ADDR_W+1 +: BANK_W];
   assign cmd_addr_o              = pop_data[1 +: ADDR_W];
   assign cmd_flag_o              = pop_data[0];
   assign cmd_overflow_o          = cur.overflow;
   assign burst_length_o          = cur.mode[MR_BL_LO +: 3];
   assign burst_interleave_o      = cur.mode[MR_BT];
   assign read_latency_o          = cur.latency;
   assign write_single_o          = cur.mode[MR_WB];
   assign partial_array_refresh_o = cur.ext_mode[EMR_PAR_LO +: 3];
   assign temp_comp_refresh_o     = cur.ext_mode[EMR_TCR_LO +: 2];
   assign temp_sensor_en_o        = cur.sensor_en;
   assign bank_open_o             = cur.bank_open;
   assign self_refresh_o          = cur.self_ref;
   assign deep_power_down_o       = cur.deep_pd;
   assign refresh_pulse_o         = cur.ref_pulse;
   assign refresh_bank_o          = cur.ref_bank;
   assign refresh_row_o           = cur.ref_row;
   assign dq_oe_o                 = cur.dq_oe;
   assign write_mask_o            = cur.wmask;

   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (!resetn_i);

   sequence s_mrs_ext;
      is_mrs && ba == SEL_EXT_MR;
   endsequence
   sequence s_sensor_follows;
      ##1 temp_sensor_en_o == ($past(addr[EMR_TCR_LO +: 2]) == TCR_SENSOR);
   endsequence
   a_tcr_sensor_sel: assert property (s_mrs_ext |-> s_sensor_follows)
      else $error("sensor enable does not follow temp-comp code");
   a_nop_no_push: assert property ((!sel || rcw == 3'b111) |-> !push)
      else $error("deselect or nop started a command");
   a_act_bank_open: assert property (is_act |=> bank_open_o[$past(ba)])
      else $error("activate did not open bank");
   a_read_latency_oe: assert property (is_rd && read_latency_o == LAT_THREE ##1 cke |=> !dq_oe_o)
      else $error("read data driven before latency");
   a_deep_pd_entry: assert property (is_bst && !cke |=> deep_power_down_o)
      else $error("deep power down not entered");
   a_pre_all_close: assert property (is_pre && addr[A_AUTO_PRE] |=> bank_open_o == '0)
      else $error("precharge all left a bank open");
   a_self_ref_entry: assert property (is_ref && !cke |=> self_refresh_o ##1 !refresh_pulse_o)
      else $error("self refresh entry wrong");
   a_auto_ref_count: assert property (is_ref && cke |=>
                                      refresh_pulse_o && refresh_row_o == $past(cur.ref_row) + 13'h0001)
      else $error("refresh counter did not advance");
   a_mrs_main_write: assert property (is_mrs && ba == SEL_MAIN_MR |=>
                                      burst_length_o == $past(addr[MR_BL_LO +: 3]))
      else $error("main mode register not written");
   a_dqm_float_read: assert property (dq_oe_o |-> !$past(dqm, 2))
      else $error("outputs driven while mask was high");
endmodule

// ### sdcmd_ctrl_model.sv
/*
 Controller model that drives the command, bank, address and mask pins.
 Assumes one clock; the bench calls issue and waits for it to return.
*/
`timescale 1ns/10ps
module sdcmd_ctrl_model (
   input  wire logic        sys_clk_i,
   output logic             cke_o,
   output logic             cs_n_o,
   output logic             ras_n_o,
   output logic             cas_n_o,
   output logic             we_n_o,
   output logic             dqm_o,
   output logic [1:0]       ba_o,
   output logic [12:0]      addr_o
);
   import sdcmd_pkg::*;

   initial {cke_o, cs_n_o, ras_n_o, cas_n_o, we_n_o, dqm_o, ba_o, addr_o} = {6'h3E, 15'h0000};

   task automatic issue(input logic [3:0] c, input logic k, input logic m, input logic [1:0] b,
                        input logic [12:0] a);
      @(posedge sys_clk_i);
      {cs_n_o, ras_n_o, cas_n_o, we_n_o} <= c;
      cke_o <= k;
      dqm_o <= m;
      ba_o <= b;
      addr_o <= a;
      @(posedge sys_clk_i);
      {cs_n_o, ras_n_o, cas_n_o, we_n_o} <= 4'hF;
      cke_o <= k;
      dqm_o <= 1'b0;
      ba_o <= ~b;
      addr_o <= ~a;
      // Spacing covers the mode set wait and all activate delays
      repeat (SAME_BANK_ACTIVATE_PERIOD_CK) @(posedge sys_clk_i);
   endtask
endmodule

// ### tb_sdcmd.sv
/*
 Self-checking bench of the command interface core.
 Assumes the controller model drives the pins; the bench consumes the command stream.
*/
`timescale 1ns/10ps
module tb;
   import sdcmd_pkg::*;
   logic              sys_clk_i = 1'b0;
   logic              resetn_i = 1'b0;
   logic              cmd_ready_i = 1'b1;
   logic              cke_i, cs_n_i, ras_n_i, cas_n_i, we_n_i, dqm_i, cmd_valid_o, cmd_flag_o;
   logic              cmd_overflow_o, temp_sensor_en_o, refresh_pulse_o, write_mask_o, last_flag;
   logic [1:0]        ba_i, cmd_bank_o, read_latency_o, temp_comp_refresh_o, refresh_bank_o;
   logic [12:0]       addr_i, refresh_row_o;
   logic [3:0]        bank_open_o;
   logic              self_refresh_o, deep_power_down_o, dq_oe_o;
   logic [2:0]        partial_array_refresh_o;
   sdcmd_kind_type    cmd_kind_o, last_kind;
   int                errors = 0, total_checks = 0, pops = 0, masks = 0, pulses = 0, oes = 0, p;

   sdcmd_ctrl_model ctl (.sys_clk_i, .cke_o(cke_i), .cs_n_o(cs_n_i), .ras_n_o(ras_n_i),
      .cas_n_o(cas_n_i), .we_n_o(we_n_i), .dqm_o(dqm_i), .ba_o(ba_i), .addr_o(addr_i));
   sdcmd_core #(.SR_TICK_CYCLES(4)) dut (.sys_clk_i, .resetn_i, .cke_i, .cs_n_i, .ras_n_i, .cas_n_i,
      .we_n_i, .dqm_i, .ba_i, .addr_i, .cmd_valid_o, .cmd_ready_i, .cmd_kind_o, .cmd_bank_o,
      .cmd_addr_o(), .cmd_flag_o, .cmd_overflow_o, .burst_length_o(), .burst_interleave_o(),
      .read_latency_o, .write_single_o(), .partial_array_refresh_o, .temp_comp_refresh_o,
      .temp_sensor_en_o, .bank_open_o, .self_refresh_o, .deep_power_down_o, .refresh_pulse_o,
      .refresh_bank_o, .refresh_row_o, .dq_oe_o, .write_mask_o);

   always #12.5 sys_clk_i = ~sys_clk_i;

   always @(posedge sys_clk_i)
   begin
      if (cmd_valid_o === 1'b1 && cmd_ready_i)
      begin
         pops++;
         last_kind = cmd_kind_o;
         last_flag = cmd_flag_o;
      end
      if (write_mask_o === 1'b1) masks++;
      if (refresh_pulse_o === 1'b1) pulses++;
      if (dq_oe_o === 1'b1) oes++;
   end

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         errors++;
         $display("[FAIL] %0t got %0h exp %0h", $time, got, exp);
      end
   endtask

   task automatic cmd(input logic [3:0] c, input logic m, input logic [1:0] b, input logic [12:0] a);
      ctl.issue(c, 1'b1, m, b, a);
      repeat (2) @(posedge sys_clk_i);
      #1;
   endtask

   task automatic t_mode;
      chk(read_latency_o, LAT_TWO);
      chk(temp_sensor_en_o, 16'h1);
      cmd(4'h0, 1'b0, SEL_MAIN_MR, 13'h0030);
      chk(read_latency_o, LAT_THREE);
      cmd(4'h0, 1'b0, SEL_EXT_MR, 13'h000E);
      chk(temp_comp_refresh_o, 16'h1);
      chk(partial_array_refresh_o, 16'h6);
      chk(temp_sensor_en_o, 16'h0);
      cmd(4'h0, 1'b0, 2'h1, 13'h0020);
      chk(read_latency_o, LAT_THREE);
      chk(temp_comp_refresh_o, 16'h1);
   endtask

   task automatic t_bank;
      cmd(4'h3, 1'b0, 2'h1, 13'h0ABC);
      chk(bank_open_o, 16'h2);
      chk(last_kind, SDCMD_ACTIVATE);
      cmd(4'h4, 1'b1, 2'h1, 13'h0400);
      chk(last_kind, SDCMD_WRITE);
      chk(last_flag, 16'h1);
      chk(masks, 16'h1);
      chk(bank_open_o, 16'h0);
      cmd(4'h3, 1'b0, 2'h1, 13'h0ABC);
      cmd(4'h3, 1'b0, 2'h2, 13'h0005);
      p = pops;
      cmd(4'h7, 1'b0, 2'h0, 13'h0000);
      cmd(4'hF, 1'b0, 2'h3, 13'h0400);
      chk(pops, p);
      chk(bank_open_o, 16'h6);
      cmd(4'h2, 1'b0, 2'h1, 13'h0000);
      chk(bank_open_o, 16'h4);
      cmd(4'h2, 1'b0, 2'h0, 13'h0400);
      chk(bank_open_o, 16'h0);
   endtask

   task automatic t_refresh;
      cmd(4'h1, 1'b0, 2'h3, 13'h1FFF);
      chk(pulses, 16'h1);
      chk({refresh_bank_o, refresh_row_o}, 16'h1);
   endtask

   task automatic t_overflow;
      @(posedge sys_clk_i) cmd_ready_i <= 1'b0;
      p = pops;
      repeat (3) cmd(4'h2, 1'b0, 2'h0, 13'h0400);
      chk(cmd_valid_o, 16'h1);
      chk(cmd_overflow_o, 16'h1);
      @(posedge sys_clk_i) cmd_ready_i <= 1'b1;
      repeat (4) @(posedge sys_clk_i);
      chk(pops, p + 2);
   endtask

   task automatic t_power;
      p = pulses;
      ctl.issue(4'h1, 1'b0, 1'b0, 2'h0, 13'h0000);
      repeat (20) @(posedge sys_clk_i);
      #1;
      chk(self_refresh_o, 16'h1);
      chk(pulses - p, 16'h5);
      chk({refresh_bank_o, refresh_row_o}, 16'h6);
      cmd(4'h7, 1'b0, 2'h0, 13'h0000);
      chk(self_refresh_o, 16'h0);
      ctl.issue(4'h6, 1'b0, 1'b0, 2'h0, 13'h0000);
      #1;
      chk(deep_power_down_o, 16'h1);
      cmd(4'h7, 1'b0, 2'h0, 13'h0000);
      chk(deep_power_down_o, 16'h0);
      cmd(4'h3, 1'b0, 2'h0, 13'h0000);
      cmd(4'h5, 1'b0, 2'h0, 13'h0000);
      chk(last_kind, SDCMD_READ);
      chk(oes, 16'h1);
   endtask

   task automatic complete_run;
      $display("errors=%0d total_checks=%0d", errors, total_checks);
      if (errors == 0 && total_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   initial
   begin
      repeat (6) @(posedge sys_clk_i);
      resetn_i <= 1'b1;
      #1;
      t_mode();
      t_bank();
      t_refresh();
      t_overflow();
      t_power();
      complete_run();
   end

   initial
   begin
      repeat (2000) @(posedge sys_clk_i);
      errors++;
      complete_run();
   end
endmodule
